/* verilog/usb_ep_pkg.sv */
package usb_ep_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 8;
  localparam int BUF_AW = 3;
  localparam int BUF_SEL_BIT = 3;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam int STAT_LSB = 4;
  localparam int STAT_ACK = 0;
  localparam int STAT_OUT = 1;
  localparam int STAT_IN = 2;
  localparam int STAT_SETUP = 3;
  localparam int CNT_DVAL_BIT = 6;
  localparam int CNT_TGL_BIT = 7;
  localparam logic [3:0] RX_MAX_CNT = 4'ha;
  localparam logic [3:0] ZLP_CNT = 4'h2;
  localparam logic [3:0] CNT_SAT = 4'hf;
  localparam logic [3:0] TX0_LEN = 4'h0;
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
  localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MODE_ISO_OUT = 4'h5;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_ISO_IN = 4'h7;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_NAK_OUT_STIN = 4'ha;
  localparam logic [3:0] MODE_ACK_OUT_STIN = 4'hb;
  localparam logic [3:0] MODE_NAK_IN = 4'hc;
  localparam logic [3:0] MODE_ACK_IN = 4'hd;
  localparam logic [3:0] MODE_NAK_IN_STOUT = 4'he;
  localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hf;
  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} tok_t;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_t;
  typedef enum logic [3:0] {
    R_IGN, R_ACPT, R_NAK, R_STALL, R_TX0, R_TXCNT, R_CHECK, R_ACKD, R_ALWAYS
  } resp_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} eng_state_t;
endpackage

/* verilog/ep_buf_if.sv */
interface ep_buf_if #(
  parameter int AW = 3,
  parameter int DW = 8
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic byp_en;
  logic [DW-1:0] byp_data;
  logic [DW-1:0] rd_data;
  logic [AW-1:0] tx_addr;
  logic [DW-1:0] tx_data;
  modport owner (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr, byp_en, byp_data, tx_addr,
    input rd_data, tx_data
  );
  modport mem (
    input wr_en, wr_addr, wr_data, rd_en, rd_addr, byp_en, byp_data, tx_addr,
    output rd_data, tx_data
  );
endinterface

/* verilog/ep_buf_mem.sv */
module ep_buf_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  ep_buf_if.mem bus
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rd_q;
  logic [DW-1:0] tx_q;

  // Read port also carries register words, so the bus read data is one flop
  assign bus.rd_data = rd_q;
  assign bus.tx_data = tx_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= '0;
      end
    end else if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= '0;
      tx_q <= '0;
    end else begin
      tx_q <= mem_q[bus.tx_addr];
      if (bus.rd_en) begin
        rd_q <= bus.byp_en ? bus.byp_data : mem_q[bus.rd_addr];
      end
    end
  end
endmodule

/* verilog/usb_endpoint_mode_engine.sv */
// Contract
// - Reset puts the endpoint in disabled mode; only firmware leaves it.
// - Mode 0000 ignores all tokens: no handshake, status or interrupt.
// - Accepted Setup rewrites mode to 0001; never from mode 0000.
// - Setup-accepting modes ACK a valid Setup data packet.
// - Mode 1001 ACKs valid Out then moves to 1000; Setup, In ignored.
// - Mode 1011 takes Setup, sends zero length on In, ACKs Out, then 1010.
// - Mode 1101 sends count on In; host ACK moves it to 1100.
// - Mode 1111 takes Setup, sends count, checks Out; acked In gives 1110.
// - Setup, In and Out status bits record the received token kind.
// - Status check accepts Out only when zero length with toggle one.
// - Only valid transactions get a handshake; invalid ones get none.
// - Interrupt on valid completion or on buffer corrupted by receive.
// - Data valid only if count with CRC is at most 10 and checks pass.
// - Modes not accepting Setup ignore Setup tokens.
// - Out-configured modes ignore In; In-configured modes ignore Out.
// - In and Out status bits are set at transaction end.
// - Setup status bit is set when the Setup data phase begins.
// - ACKed transaction locks mode and count registers against CPU writes.
// - Lock clears only on CPU read after the transaction completes.
//
// Design decisions made here: the strobed register port and the placing of the registers.
module usb_endpoint_mode_engine #(
  parameter int BUF_DEPTH = usb_ep_pkg::BUF_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [usb_ep_pkg::ADDR_W-1:0] i_addr,
  input wire logic [usb_ep_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [usb_ep_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_tok_valid,
  input wire usb_ep_pkg::tok_t i_tok_kind,
  input wire logic i_data_start,
  input wire logic i_data_valid,
  input wire logic [usb_ep_pkg::DATA_W-1:0] i_data_byte,
  input wire logic i_data_end,
  input wire logic i_data_ok,
  input wire logic i_data_tgl,
  input wire logic i_host_ack,
  output logic o_hs_valid,
  output usb_ep_pkg::hs_t o_hs_code,
  output logic o_tx_start,
  output logic [3:0] o_tx_len,
  output logic o_tx_tgl,
  input wire logic [usb_ep_pkg::BUF_AW-1:0] i_tx_idx,
  output logic [usb_ep_pkg::DATA_W-1:0] o_tx_byte,
  output logic o_irq,
  output logic o_locked
);
  import usb_ep_pkg::*;

  // Setup is refused by the disabled mode and by the data-only modes
  function automatic logic setup_ok(logic [3:0] m);
    unique case (m)
      MODE_DISABLE: setup_ok = 1'b0;
      MODE_NAK_INOUT: setup_ok = 1'b1;
      MODE_STATUS_OUT: setup_ok = 1'b1;
      MODE_STALL_INOUT: setup_ok = 1'b1;
      MODE_IGNORE_INOUT: setup_ok = 1'b1;
      MODE_ISO_OUT: setup_ok = 1'b0;
      MODE_STATUS_IN: setup_ok = 1'b1;
      MODE_ISO_IN: setup_ok = 1'b0;
      MODE_NAK_OUT: setup_ok = 1'b0;
      MODE_ACK_OUT: setup_ok = 1'b0;
      MODE_NAK_OUT_STIN: setup_ok = 1'b1;
      MODE_ACK_OUT_STIN: setup_ok = 1'b1;
      MODE_NAK_IN: setup_ok = 1'b0;
      MODE_ACK_IN: setup_ok = 1'b0;
      MODE_NAK_IN_STOUT: setup_ok = 1'b1;
      MODE_ACK_IN_STOUT: setup_ok = 1'b1;
    endcase
  endfunction

  function automatic resp_t in_resp(logic [3:0] m);
    unique case (m)
      MODE_DISABLE: in_resp = R_IGN;
      MODE_NAK_INOUT: in_resp = R_NAK;
      MODE_STATUS_OUT: in_resp = R_STALL;
      MODE_STALL_INOUT: in_resp = R_STALL;
      MODE_IGNORE_INOUT: in_resp = R_IGN;
      MODE_ISO_OUT: in_resp = R_IGN;
      MODE_STATUS_IN: in_resp = R_TX0;
      MODE_ISO_IN: in_resp = R_TXCNT;
      MODE_NAK_OUT: in_resp = R_IGN;
      MODE_ACK_OUT: in_resp = R_IGN;
      MODE_NAK_OUT_STIN: in_resp = R_TX0;
      MODE_ACK_OUT_STIN: in_resp = R_TX0;
      MODE_NAK_IN: in_resp = R_NAK;
      MODE_ACK_IN: in_resp = R_TXCNT;
      MODE_NAK_IN_STOUT: in_resp = R_NAK;
      MODE_ACK_IN_STOUT: in_resp = R_TXCNT;
    endcase
  endfunction

  function automatic resp_t out_resp(logic [3:0] m);
    unique case (m)
      MODE_DISABLE: out_resp = R_IGN;
      MODE_NAK_INOUT: out_resp = R_NAK;
      MODE_STATUS_OUT: out_resp = R_CHECK;
      MODE_STALL_INOUT: out_resp = R_STALL;
      MODE_IGNORE_INOUT: out_resp = R_IGN;
      MODE_ISO_OUT: out_resp = R_ALWAYS;
      MODE_STATUS_IN: out_resp = R_STALL;
      MODE_ISO_IN: out_resp = R_IGN;
      MODE_NAK_OUT: out_resp = R_NAK;
      MODE_ACK_OUT: out_resp = R_ACKD;
      MODE_NAK_OUT_STIN: out_resp = R_NAK;
      MODE_ACK_OUT_STIN: out_resp = R_ACKD;
      MODE_NAK_IN: out_resp = R_IGN;
      MODE_ACK_IN: out_resp = R_IGN;
      MODE_NAK_IN_STOUT: out_resp = R_CHECK;
      MODE_ACK_IN_STOUT: out_resp = R_CHECK;
    endcase
  endfunction

  function automatic logic [3:0] ack_next(logic [3:0] m);
    unique case (m)
      MODE_ACK_OUT: ack_next = MODE_NAK_OUT;
      MODE_ACK_OUT_STIN: ack_next = MODE_NAK_OUT_STIN;
      MODE_ACK_IN: ack_next = MODE_NAK_IN;
      MODE_ACK_IN_STOUT: ack_next = MODE_NAK_IN_STOUT;
      default: ack_next = m;
    endcase
  endfunction

  // NAK or STALL only; an ACK is forced after the checks
  function automatic hs_t hs_of(resp_t r);
    unique case (r)
      R_NAK: hs_of = HS_NAK;
      default: hs_of = HS_STALL;
    endcase
  endfunction

  eng_state_t st_q, st_d;
  resp_t resp_q, resp_d;
  tok_t tok_q, tok_d;
  logic [3:0] rxcnt_q, rxcnt_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] count_q, count_d;
  logic lock_q, lock_d;
  logic hs_v_q, hs_v_d;
  hs_t hs_c_q, hs_c_d;
  logic tx_start_q, tx_start_d;
  logic [3:0] tx_len_q, tx_len_d;
  logic tx_tgl_q, tx_tgl_d;
  logic irq_q, irq_d;
  logic [3:0] stat_set;
  logic ack_rx, ack_in, rx_we;
  logic hw_mode_we, hw_cnt_we;
  logic [3:0] hw_mode;
  logic hw_dval, hw_tgl;

  ep_buf_if #(.AW(BUF_AW), .DW(DATA_W)) buf_bus ();

  ep_buf_mem #(.DEPTH(BUF_DEPTH), .AW(BUF_AW), .DW(DATA_W)) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .bus(buf_bus.mem)
  );

  wire [3:0] mode_f = mode_q[3:0];
  wire resp_t tok_resp = (mode_f == MODE_DISABLE) ? R_IGN :
    (i_tok_kind == TOK_SETUP) ? (setup_ok(mode_f) ? R_ACPT : R_IGN) :
    (i_tok_kind == TOK_IN) ? in_resp(mode_f) : out_resp(mode_f);
  // An ignored token does not even leave idle
  wire tok_take = i_tok_valid && (tok_resp != R_IGN);
  wire valid_pkt = i_data_ok && (rxcnt_q <= RX_MAX_CNT);
  wire buffered = (resp_q == R_ACPT) || (resp_q == R_ACKD) || (resp_q == R_ALWAYS);
  wire zlp_ok = (rxcnt_q == ZLP_CNT) && i_data_tgl;
  wire rx_in_buf = rxcnt_q < 4'(BUF_DEPTH);

  // CPU side decode
  wire sel_buf = i_addr[BUF_SEL_BIT];
  wire cpu_wr_mode = i_wr && (i_addr == ADDR_MODE) && !lock_q;
  wire cpu_wr_cnt = i_wr && (i_addr == ADDR_COUNT) && !lock_q;
  wire cpu_rd_regs = i_rd && ((i_addr == ADDR_MODE) || (i_addr == ADDR_COUNT));
  // Reads during a transaction do not count, so firmware cannot race the engine
  wire unlock = cpu_rd_regs && (st_q == ST_IDLE);
  wire [7:0] reg_rdata = (i_addr == ADDR_MODE) ? mode_q :
    (i_addr == ADDR_COUNT) ? count_q : 8'h00;

  // Receive wins the buffer write port; a CPU buffer write in that cycle is lost
  assign buf_bus.wr_en = rx_we || (i_wr && sel_buf);
  assign buf_bus.wr_addr = rx_we ? rxcnt_q[BUF_AW-1:0] : i_addr[BUF_AW-1:0];
  assign buf_bus.wr_data = rx_we ? i_data_byte : i_wdata;
  assign buf_bus.rd_en = i_rd;
  assign buf_bus.rd_addr = i_addr[BUF_AW-1:0];
  assign buf_bus.byp_en = !sel_buf;
  assign buf_bus.byp_data = reg_rdata;
  assign buf_bus.tx_addr = i_tx_idx;

  always_comb begin
    st_d = st_q;
    resp_d = resp_q;
    tok_d = tok_q;
    rxcnt_d = rxcnt_q;
    hs_v_d = 1'b0;
    hs_c_d = hs_c_q;
    tx_start_d = 1'b0;
    tx_len_d = tx_len_q;
    tx_tgl_d = tx_tgl_q;
    irq_d = 1'b0;
    stat_set = 4'h0;
    ack_rx = 1'b0;
    ack_in = 1'b0;
    rx_we = 1'b0;
    hw_cnt_we = 1'b0;
    hw_dval = count_q[CNT_DVAL_BIT];
    hw_tgl = count_q[CNT_TGL_BIT];
    unique case (st_q)
      ST_IDLE: begin
        if (tok_take) begin
          resp_d = tok_resp;
          tok_d = i_tok_kind;
          if (i_tok_kind == TOK_IN) begin
            if (tok_resp == R_NAK || tok_resp == R_STALL) begin
              hs_v_d = 1'b1;
              hs_c_d = hs_of(tok_resp);
              stat_set[STAT_IN] = 1'b1;
              irq_d = 1'b1;
            end else begin
              tx_start_d = 1'b1;
              tx_len_d = (tok_resp == R_TX0) ? TX0_LEN : count_q[3:0];
              tx_tgl_d = count_q[CNT_TGL_BIT];
              st_d = ST_TX;
            end
          end else begin
            rxcnt_d = 4'h0;
            st_d = ST_RX;
          end
        end
      end
      ST_RX: begin
        if (i_data_start && tok_q == TOK_SETUP) begin
          stat_set[STAT_SETUP] = 1'b1;
        end
        if (i_data_valid) begin
          rx_we = buffered && rx_in_buf;
          rxcnt_d = (rxcnt_q == CNT_SAT) ? CNT_SAT : rxcnt_q + 4'h1;
        end
        if (i_data_end) begin
          st_d = ST_IDLE;
          stat_set[STAT_OUT] = (tok_q == TOK_OUT) && (buffered || valid_pkt);
          if (buffered) begin
            // Buffer was written even if the packet turns out bad
            hw_cnt_we = 1'b1;
            hw_dval = valid_pkt;
            hw_tgl = i_data_tgl;
            irq_d = 1'b1;
            ack_rx = valid_pkt && (resp_q != R_ALWAYS);
          end else if (valid_pkt) begin
            irq_d = 1'b1;
            hs_v_d = 1'b1;
            hs_c_d = hs_of(resp_q);
            if (resp_q == R_CHECK) begin
              hw_cnt_we = 1'b1;
              hw_dval = 1'b1;
              hw_tgl = i_data_tgl;
              ack_rx = zlp_ok;
            end
          end
        end
      end
      ST_TX: begin
        // A new token abandons the In; host stays silent on a lost packet
        if (i_host_ack || i_tok_valid) begin
          st_d = ST_IDLE;
          stat_set[STAT_IN] = 1'b1;
          irq_d = 1'b1;
          ack_in = i_host_ack;
        end
      end
    endcase
    if (ack_rx) begin
      hs_v_d = 1'b1;
      hs_c_d = HS_ACK;
    end
  end

  assign hw_mode_we = ack_rx || ack_in;
  // A passed status check keeps its mode; only data ACKs advance it
  wire [3:0] ack_mode = (resp_q == R_CHECK) ? mode_f : ack_next(mode_f);
  assign hw_mode = (tok_q == TOK_SETUP) ? MODE_NAK_INOUT : ack_mode;

  wire [3:0] ack_set = {3'b000, hw_mode_we};
  wire [3:0] stat_wr = cpu_wr_mode ? i_wdata[7:4] : mode_q[7:4];
  wire [3:0] mode_wr = cpu_wr_mode ? i_wdata[3:0] : mode_f;
  // Hardware set wins over a firmware clear in the same cycle
  assign mode_d = {stat_wr | stat_set | ack_set,
    hw_mode_we ? hw_mode : mode_wr};
  wire [7:0] cnt_wr = cpu_wr_cnt ? i_wdata : count_q;
  assign count_d = hw_cnt_we ? {hw_tgl, hw_dval, 2'b00, rxcnt_q} : cnt_wr;
  assign lock_d = hw_mode_we || (lock_q && !unlock);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      resp_q <= R_IGN;
      tok_q <= TOK_SETUP;
      rxcnt_q <= 4'h0;
      mode_q <= MODE_RST;
      count_q <= COUNT_RST;
      lock_q <= 1'b0;
    end else begin
      st_q <= st_d;
      resp_q <= resp_d;
      tok_q <= tok_d;
      rxcnt_q <= rxcnt_d;
      mode_q <= mode_d;
      count_q <= count_d;
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hs_v_q <= 1'b0;
      hs_c_q <= HS_ACK;
      tx_start_q <= 1'b0;
      tx_len_q <= 4'h0;
      tx_tgl_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      hs_v_q <= hs_v_d;
      hs_c_q <= hs_c_d;
      tx_start_q <= tx_start_d;
      tx_len_q <= tx_len_d;
      tx_tgl_q <= tx_tgl_d;
      irq_q <= irq_d;
    end
  end

  assign o_rdata = buf_bus.rd_data;
  assign o_tx_byte = buf_bus.tx_data;
  assign o_hs_valid = hs_v_q;
  assign o_hs_code = hs_c_q;
  assign o_tx_start = tx_start_q;
  assign o_tx_len = tx_len_q;
  assign o_tx_tgl = tx_tgl_q;
  assign o_irq = irq_q;
  assign o_locked = lock_q;
endmodule

/* sim/usb_ep_asserts.sv */
module usb_ep_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rd,
  input wire logic i_tok_valid,
  input wire usb_ep_pkg::tok_t i_tok_kind,
  input wire logic i_data_start,
  input wire logic i_data_valid,
  input wire logic i_data_end,
  input wire logic i_data_ok,
  input wire logic i_host_ack,
  input wire logic o_hs_valid,
  input wire usb_ep_pkg::hs_t o_hs_code,
  input wire logic o_tx_start,
  input wire logic o_irq,
  input wire logic o_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  import usb_ep_pkg::*;
  logic tx_pend_q;
  logic [4:0] rx_cnt_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // A host ack only counts while our In data is out
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      tx_pend_q <= 1'b0;
    else if (o_tx_start)
      tx_pend_q <= 1'b1;
    else if (i_tok_valid || i_host_ack)
      tx_pend_q <= 1'b0;
  end
  // Saturates so a runaway packet never wraps to a legal size
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      rx_cnt_q <= 5'h00;
    else if (i_data_start)
      rx_cnt_q <= 5'h00;
    else if (i_data_valid && rx_cnt_q != 5'h1f)
      rx_cnt_q <= rx_cnt_q + 5'h01;
  end
  a_ack_locks: assert property (o_hs_valid && o_hs_code == HS_ACK |-> o_locked)
    else $error("ACK sent without write lock");
  a_ack_irq: assert property (o_hs_valid && o_hs_code == HS_ACK |-> o_irq)
    else $error("ACK sent without interrupt");
  a_host_ack_done: assert property (i_host_ack && tx_pend_q |=> o_locked && o_irq)
    else $error("host ack did not complete the In");
  a_lock_holds: assert property (o_locked && !i_rd |=> o_locked)
    else $error("lock dropped without a read");
  a_bad_silent: assert property (i_data_end && !i_data_ok |=> !o_hs_valid)
    else $error("handshake for a failed packet");
  a_long_silent: assert property (i_data_end && rx_cnt_q > 5'h0a |=> !o_hs_valid)
    else $error("handshake for an oversized packet");
  a_hs_cause: assert property (o_hs_valid |-> $past(i_data_end) || $past(i_tok_valid))
    else $error("handshake without a cause");
  a_tx_cause: assert property (o_tx_start |-> $past(i_tok_valid && i_tok_kind == TOK_IN))
    else $error("transmit without an In token");
endmodule

bind usb_endpoint_mode_engine usb_ep_asserts i_usb_ep_asserts (
  .i_clk_sys, .i_rst_n, .i_rd, .i_tok_valid, .i_tok_kind, .i_data_start, .i_data_valid,
  .i_data_end, .i_data_ok, .i_host_ack, .o_hs_valid, .o_hs_code, .o_tx_start, .o_irq,
  .o_locked
);

/* sim/usb_host_model.sv */
module usb_host_model (
  input wire logic i_clk_sys,
  output logic o_tok_valid,
  output usb_ep_pkg::tok_t o_tok_kind,
  output logic o_data_start,
  output logic o_data_valid,
  output logic [7:0] o_data_byte,
  output logic o_data_end,
  output logic o_data_ok,
  output logic o_data_tgl,
  output logic o_host_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  import usb_ep_pkg::*;
  initial begin
    {o_tok_valid, o_data_start, o_data_valid, o_data_end, o_host_ack} = 5'h00;
    {o_data_ok, o_data_tgl, o_data_byte} = 10'h000;
    o_tok_kind = TOK_SETUP;
  end
  task automatic token(input tok_t kind);
    @(posedge i_clk_sys);
    o_tok_valid <= 1'b1;
    o_tok_kind <= kind;
    @(posedge i_clk_sys);
    o_tok_valid <= 1'b0;
  endtask
  // Count includes the CRC bytes
  task automatic packet(input int n, input logic ok, input logic tgl);
    @(posedge i_clk_sys);
    o_data_start <= 1'b1;
    @(posedge i_clk_sys);
    o_data_start <= 1'b0;
    for (int k = 0; k < n; k++) begin
      o_data_valid <= 1'b1;
      o_data_byte <= 8'h30 + 8'(k);
      @(posedge i_clk_sys);
    end
    // Released lines flip so a stale value never looks held
    o_data_valid <= 1'b0;
    o_data_byte <= ~o_data_byte;
    o_data_end <= 1'b1;
    o_data_ok <= ok;
    o_data_tgl <= tgl;
    @(posedge i_clk_sys);
    o_data_end <= 1'b0;
    o_data_ok <= ~ok;
    o_data_tgl <= ~tgl;
  endtask
  task automatic ack();
    @(posedge i_clk_sys);
    o_host_ack <= 1'b1;
    @(posedge i_clk_sys);
    o_host_ack <= 1'b0;
  endtask
endmodule

/* sim/usb_endpoint_mode_engine_tb.sv */
module usb_endpoint_mode_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import usb_ep_pkg::*;
  logic i_clk_sys, i_rst_n, i_wr, i_rd, i_tok_valid, i_data_start, i_data_valid;
  logic i_data_end, i_data_ok, i_data_tgl, i_host_ack, o_hs_valid, o_tx_start;
  logic o_tx_tgl, o_irq, o_locked, irq_got;
  logic [3:0] i_addr, o_tx_len;
  logic [7:0] i_wdata, o_rdata, i_data_byte, o_tx_byte;
  logic [2:0] i_tx_idx, hs_got;
  logic [4:0] tx_got;
  tok_t i_tok_kind;
  hs_t o_hs_code;
  int num_errors = 0;
  int checks_done = 0;
  usb_endpoint_mode_engine i_usb_endpoint_mode_engine (.i_clk_sys, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tok_valid, .i_tok_kind, .i_data_start,
    .i_data_valid, .i_data_byte, .i_data_end, .i_data_ok, .i_data_tgl, .i_host_ack,
    .o_hs_valid, .o_hs_code, .o_tx_start, .o_tx_len, .o_tx_tgl, .i_tx_idx, .o_tx_byte,
    .o_irq, .o_locked);
  usb_host_model i_usb_host_model (.i_clk_sys, .o_tok_valid(i_tok_valid),
    .o_tok_kind(i_tok_kind), .o_data_start(i_data_start), .o_data_valid(i_data_valid),
    .o_data_byte(i_data_byte), .o_data_end(i_data_end), .o_data_ok(i_data_ok),
    .o_data_tgl(i_data_tgl), .o_host_ack(i_host_ack));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // Output pulses are latched so a check need not hit their one cycle
  always @(posedge i_clk_sys) begin
    if (o_hs_valid === 1'b1)
      hs_got = {1'b1, o_hs_code};
    if (o_tx_start === 1'b1)
      tx_got = {1'b1, o_tx_len};
    if (o_irq === 1'b1)
      irq_got = 1'b1;
  end
  function automatic logic [11:0] obs();
    return {3'h0, irq_got, hs_got, tx_got};
  endfunction
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    check({4'h0, o_rdata}, {4'h0, e});
  endtask
  // n below zero means a token with no data packet
  task automatic xfer(input tok_t kind, input int n, input logic ok, input logic tgl);
    @(negedge i_clk_sys);
    {irq_got, hs_got, tx_got} = 9'h000;
    i_usb_host_model.token(kind);
    if (n >= 0)
      i_usb_host_model.packet(n, ok, tgl);
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic t_disabled();
    rdc(ADDR_MODE, MODE_RST);
    rdc(ADDR_COUNT, COUNT_RST);
    rdc(4'h2, 8'h00);
    for (int k = 0; k < 3; k++) begin
      xfer(tok_t'(k), (k == 1) ? -1 : 3, 1'b1, 1'b0);
      check(obs(), 12'h000);
    end
    rdc(ADDR_MODE, 8'h00);
    $display("t_disabled finished");
  endtask
  task automatic t_setup();
    wr(ADDR_MODE, 8'h0b);
    xfer(TOK_SETUP, 10, 1'b1, 1'b0);
    check(obs(), 12'h180);
    check({11'h0, o_locked}, 12'h001);
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_COUNT, 8'h00);
    rdc(ADDR_MODE, 8'h91);
    check({11'h0, o_locked}, 12'h000);
    rdc(ADDR_COUNT, 8'h4a);
    $display("t_setup finished");
  endtask
  task automatic t_out();
    wr(ADDR_MODE, 8'h09);
    xfer(TOK_IN, -1, 1'b1, 1'b0);
    check(obs(), 12'h000);
    xfer(TOK_SETUP, 4, 1'b1, 1'b1);
    check(obs(), 12'h000);
    xfer(TOK_OUT, 4, 1'b1, 1'b1);
    check(obs(), 12'h180);
    rdc(ADDR_MODE, 8'h38);
    rdc(ADDR_COUNT, 8'hc4);
    xfer(TOK_OUT, 4, 1'b1, 1'b0);
    check(obs() & 12'h0ff, 12'h0a0);
    wr(ADDR_MODE, 8'h09);
    xfer(TOK_OUT, 11, 1'b1, 1'b0);
    check(obs(), 12'h100);
    rdc(ADDR_COUNT, 8'h0b);
    xfer(TOK_OUT, 3, 1'b0, 1'b0);
    check(obs(), 12'h100);
    $display("t_out finished");
  endtask
  task automatic t_in();
    wr(ADDR_COUNT, 8'h85);
    wr(ADDR_MODE, 8'h0d);
    xfer(TOK_OUT, 3, 1'b1, 1'b0);
    check(obs(), 12'h000);
    xfer(TOK_IN, -1, 1'b1, 1'b0);
    check(obs(), 12'h015);
    check({11'h0, o_tx_tgl}, 12'h001);
    @(posedge i_clk_sys);
    i_tx_idx <= 3'h2;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check({4'h0, o_tx_byte}, 12'h032);
    irq_got = 1'b0;
    i_usb_host_model.ack();
    repeat (2) @(negedge i_clk_sys);
    check({3'h0, irq_got, 7'h0, o_locked}, 12'h101);
    rdc(ADDR_MODE, 8'h5c);
    xfer(TOK_IN, -1, 1'b1, 1'b0);
    check(obs() & 12'h0ff, 12'h0a0);
    rdc(4'ha, 8'h32);
    $display("t_in finished");
  endtask
  task automatic t_check();
    wr(ADDR_MODE, 8'h0e);
    xfer(TOK_OUT, 2, 1'b1, 1'b1);
    check(obs(), 12'h180);
    rdc(ADDR_MODE, 8'h3e);
    xfer(TOK_OUT, 2, 1'b1, 1'b0);
    check(obs() & 12'h0ff, 12'h0c0);
    xfer(TOK_OUT, 3, 1'b1, 1'b1);
    check(obs() & 12'h0ff, 12'h0c0);
    $display("t_check finished");
  endtask
  // In answers per mode: NAK a0, stall c0, ignore 00, zero length 10
  task automatic t_in_table();
    logic [7:0] md [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09,
      8'h0a, 8'h0b, 8'h0c, 8'h0e};
    logic [7:0] ex [12] = '{8'ha0, 8'hc0, 8'hc0, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00,
      8'h10, 8'h10, 8'ha0, 8'ha0};
    for (int k = 0; k < 12; k++) begin
      wr(ADDR_MODE, md[k]);
      xfer(TOK_IN, -1, 1'b1, 1'b0);
      check(obs() & 12'h0ff, {4'h0, ex[k]});
      if (ex[k][4])
        i_usb_host_model.ack();
      rdc(ADDR_COUNT, 8'hc3);
    end
    $display("t_in_table finished");
  endtask
  task automatic t_ctrl();
    wr(ADDR_COUNT, 8'h03);
    wr(ADDR_MODE, 8'h0f);
    xfer(TOK_IN, -1, 1'b1, 1'b0);
    check(obs(), 12'h013);
    i_usb_host_model.ack();
    rdc(ADDR_MODE, 8'h5e);
    wr(ADDR_MODE, 8'h0f);
    xfer(TOK_OUT, 2, 1'b1, 1'b1);
    check(obs(), 12'h180);
    rdc(ADDR_MODE, 8'h3f);
    wr(ADDR_MODE, 8'h05);
    xfer(TOK_OUT, 5, 1'b1, 1'b0);
    check(obs(), 12'h100);
    check({11'h0, o_locked}, 12'h000);
    rdc(ADDR_COUNT, 8'h45);
    $display("t_ctrl finished");
  endtask
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_tx_idx} = 18'h00000;
    {irq_got, hs_got, tx_got} = 9'h000;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_disabled();
    t_setup();
    t_out();
    t_in();
    t_check();
    t_in_table();
    t_ctrl();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    num_errors++;
    stop_test();
  end
endmodule
